// ===== rtl/spt_defs.svh
`ifndef SPT_DEFS_SVH
`define SPT_DEFS_SVH
// Translator state numbering, 0-based index (index 0 is home state 1)
`define SPT_HOME_IDX 3'h0
`define SPT_ONE_STEP 3'h1
`define SPT_TWO_STEP 3'h2
// Home phase pattern, A is bit 3 down to D at bit 0
`define SPT_HOME_PHASE 4'h5
`define SPT_PHASE_OFF 4'h0
// Input synchroniser depth
`define SPT_SYNC_STAGES 3
`endif

// ===== rtl/spt_pkg.sv
`default_nettype none
package spt_pkg;
   // Sequencing mode decoded from the select level and state parity
   typedef enum logic [1:0] {
      SPT_MODE_HALF = 2'h0,
      SPT_MODE_NORMAL = 2'h1,
      SPT_MODE_WAVE = 2'h3
   } spt_mode_t;
endpackage
`default_nettype wire

// ===== rtl/spt_in_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "spt_defs.svh"
module spt_in_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] out_r;
   logic [WIDTH-1:0] out_nxt;

   // Value counts only once stages two and three agree, filtering one-cycle glitches
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         assign out_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : out_r[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Three-stage chain; first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         out_r <= '0;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= out_nxt;
      end
   end
   assign sync_out = out_r;
endmodule
`default_nettype wire

// ===== rtl/spt_translator.sv
`timescale 1ns/1ps
`default_nettype none
`include "spt_defs.svh"
// Operation
// [R1] One state move per rising step edge; falling edge does nothing.
// [R2] Clockwise walks the sequence forward; anticlockwise walks it backward.
// [R3] Reset low forces home state 1 with phase lines 0101.
// [R4] Select high: half-step, visiting all eight states in turn.
// [R5] Select low in odd state: jump two states, two-phase-on drive.
// [R6] Two-phase-on mode keeps both inhibit outputs high.
// [R7] Select low in even state: jump two states, one-phase-on drive.
// [R8] Enable low forces inhibits and phase lines low.
// [R9] Direction sampled in step with stepping logic; changes never corrupt state.
// [R10] Half-step and wave: inhibit low for a de-energised winding pair.
// [R11] Fixed eight-entry phase table; odd states drive both pairs.
module spt_translator (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic step_in,
   input wire logic rotation_direction,
   input wire logic half_select,
   input wire logic translator_rstn,
   input wire logic enable,
   output logic [3:0] phase_lines,
   output logic inhibit_pair_one,
   output logic inhibit_pair_two,
   output logic [2:0] state_index
);
   logic [3:0] pins_sync;
   logic step_s;
   logic dir_s;
   logic half_s;
   logic trst_n_s;
   logic step_d_r;
   logic [2:0] state_r;
   logic [2:0] state_nxt;
   logic [3:0] phase_r;
   logic [3:0] phase_nxt;
   logic inh_one_r;
   logic inh_two_r;
   logic inh_one_nxt;
   logic inh_two_nxt;
   logic step_rise;
   logic [2:0] stride;
   spt_pkg::spt_mode_t mode;
   logic [3:0] table_phase;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin inputs cross into the system clock; enable also from a pin
   spt_in_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .async_in({translator_rstn, half_select, rotation_direction, step_in}),
      .sync_out(pins_sync)
   );
   logic [0:0] en_sync;
   spt_in_sync #(
      .WIDTH(1)
   ) u_sync_en (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .async_in(enable),
      .sync_out(en_sync)
   );

   assign step_s = pins_sync[0];
   assign dir_s = pins_sync[1];
   assign half_s = pins_sync[2];
   assign trst_n_s = pins_sync[3];

   ////////////////////////////////////////////////////////////////////////////////
   // Phase table, A is bit 3; odd states (even index) drive one line per pair
   function automatic logic [3:0] spt_phase(input logic [2:0] idx);
      logic [3:0] p;
      p = `SPT_PHASE_OFF;
      unique case (idx)
         3'h0: p = 4'h5; // State 1: A off B on C off D on [R11]
         3'h1: p = 4'h4; // State 2: B only
         3'h2: p = 4'h6; // State 3: B and C
         3'h3: p = 4'h2; // State 4: C only
         3'h4: p = 4'ha; // State 5: A and C
         3'h5: p = 4'h8; // State 6: A only
         3'h6: p = 4'h9; // State 7: A and D
         3'h7: p = 4'h1; // State 8: D only
      endcase
      return p;
   endfunction

   // Odd state numbers sit at even indices
   function automatic logic spt_odd_state(input logic [2:0] idx);
      return ~idx[0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Mode and next-state decode
   assign mode = half_s ? spt_pkg::SPT_MODE_HALF : // [R4]
      (spt_odd_state(state_r) ? spt_pkg::SPT_MODE_NORMAL : spt_pkg::SPT_MODE_WAVE); // [R5] [R7]
   // Full step keeps the parity it starts from, so the mode latches itself by position
   assign stride = (mode == spt_pkg::SPT_MODE_HALF) ? `SPT_ONE_STEP : `SPT_TWO_STEP;
   assign step_rise = step_s & ~step_d_r; // [R1]
   // Direction is the synchronised level at the step edge, so a change is never torn
   // Limitation: a direction change within a few cycles of a step edge may go either way
   assign state_nxt = !step_rise ? state_r :
      (dir_s ? 3'(state_r + stride) : 3'(state_r - stride)); // [R2] [R9]
   assign table_phase = spt_phase(state_nxt);

   ////////////////////////////////////////////////////////////////////////////////
   // Inhibits: pair AB is bits 3:2, pair CD bits 1:0; normal mode holds both high
   logic next_odd;
   assign next_odd = spt_odd_state(state_nxt);
   assign phase_nxt = en_sync[0] ? table_phase : `SPT_PHASE_OFF; // [R8]
   // Inhibit follows pair activity, which also covers the odd states of half-step
   assign inh_one_nxt = en_sync[0] & (((!half_s) && next_odd) | (|table_phase[3:2])); // [R6] [R10]
   assign inh_two_nxt = en_sync[0] & (((!half_s) && next_odd) | (|table_phase[1:0])); // [R6] [R10]

   ////////////////////////////////////////////////////////////////////////////////
   // State and registered outputs; translator reset wins over a step
   // Edge history keeps tracking during translator reset, so its release is no false step
   always_ff @(posedge clk_sys) begin
      if (!rstn || !trst_n_s) begin
         state_r <= `SPT_HOME_IDX; // [R3]
         phase_r <= `SPT_PHASE_OFF;
         inh_one_r <= 1'b0;
         inh_two_r <= 1'b0;
         step_d_r <= 1'b0;
         if (rstn) begin
            phase_r <= en_sync[0] ? `SPT_HOME_PHASE : `SPT_PHASE_OFF; // [R3]
            inh_one_r <= en_sync[0];
            inh_two_r <= en_sync[0];
            step_d_r <= step_s;
         end
      end else begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         inh_one_r <= inh_one_nxt;
         inh_two_r <= inh_two_nxt;
         step_d_r <= step_s;
      end
   end

   // All outputs come straight from flip-flops, so the power stage never sees a glitch
   assign phase_lines = phase_r;
   assign inhibit_pair_one = inh_one_r;
   assign inhibit_pair_two = inh_two_r;
   assign state_index = state_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   step_once_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
      (trst_n_s && !step_rise) |=> $stable(state_r))
      else $error("state moved without a rising step");
   fwd_move_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
      (trst_n_s && step_rise && dir_s) |=> (state_r == 3'($past(state_r) + $past(stride))))
      else $error("forward step wrong");
   rev_move_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
      (trst_n_s && step_rise && !dir_s) |=> (state_r == 3'($past(state_r) - $past(stride))))
      else $error("reverse step wrong");
   home_reset_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
      (!trst_n_s && en_sync[0]) |=> (state_r == `SPT_HOME_IDX && phase_lines == `SPT_HOME_PHASE))
      else $error("reset did not reach home");
   half_stride_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
      (trst_n_s && step_rise && half_s) |=> (state_r[0] != $past(state_r[0])))
      else $error("half step kept parity");
   full_parity_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R5]
      (trst_n_s && step_rise && !half_s) |=> (state_r[0] == $past(state_r[0])))
      else $error("full step changed parity");
   normal_inhibit_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R6]
      (trst_n_s && en_sync[0] && !half_s && spt_odd_state(state_nxt))
      |=> (inhibit_pair_one && inhibit_pair_two))
      else $error("inhibit low in normal drive");
   wave_inhibit_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
      (trst_n_s && en_sync[0] && !half_s && !spt_odd_state(state_nxt))
      |=> (inhibit_pair_one != inhibit_pair_two))
      else $error("wave drive inhibits wrong");
   off_forced_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
      !en_sync[0] |=> (phase_lines == 4'h0 && !inhibit_pair_one && !inhibit_pair_two))
      else $error("outputs live while disabled");
   idle_inhibit_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
      (trst_n_s && half_s && en_sync[0]) |=> (inhibit_pair_one == (|phase_lines[3:2])))
      else $error("pair one inhibit mismatch");
   // Checked against the state the outputs are loaded with, since a step may land now
   table_odd_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
      (en_sync[0] && spt_odd_state(state_nxt))
      |=> ((|phase_lines[3:2]) && (|phase_lines[1:0])))
      else $error("odd state not driving both pairs");

   // Held translator reset keeps the state home
   home_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
      (!trst_n_s && !$past(trst_n_s)) |-> (state_r == `SPT_HOME_IDX))
      else $error("state left home during reset");

   // A seen rising edge outside translator reset always moves the state
   step_move_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
      (trst_n_s && step_rise) |=> !$stable(state_r))
      else $error("rising step did not move state");

   // A direction change between steps leaves the position alone
   dir_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
      (trst_n_s && !step_rise && $changed(dir_s)) |=> $stable(state_r))
      else $error("direction change moved state");

   // Wave drive energises exactly one line
   wave_single_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
      (trst_n_s && en_sync[0] && !half_s && !spt_odd_state(state_nxt))
      |=> $onehot(phase_lines))
      else $error("wave drive not single line");

   // Pair two inhibit tracks its pair in even states
   pair_two_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
      (trst_n_s && en_sync[0] && !spt_odd_state(state_nxt))
      |=> (inhibit_pair_two == (|phase_lines[1:0])))
      else $error("pair two inhibit mismatch");

   // While enabled some winding is always driven
   live_drive_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
      en_sync[0] |=> (phase_lines != `SPT_PHASE_OFF))
      else $error("enabled but no phase driven");

   // Main scenarios worth seeing at least once
   cov_fwd_c: cover property (@(posedge clk_sys) step_rise && dir_s && half_s);
   cov_rev_c: cover property (@(posedge clk_sys) step_rise && !dir_s && !half_s);
   cov_wrap_c: cover property (@(posedge clk_sys) state_r == 3'h7 ##[1:50] state_r == 3'h0);
   cov_off_c: cover property (@(posedge clk_sys) !en_sync[0] ##1 en_sync[0]);
   cov_home_c: cover property (@(posedge clk_sys) !trst_n_s ##1 trst_n_s);
endmodule
`default_nettype wire

// ===== tb/spt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller model: levels move only on falling edges, with wide setup and pulses
module spt_host_model (
   input wire logic clk_sys,
   output logic step_in,
   output logic rotation_direction,
   output logic half_select
);
   initial begin
      step_in = 1'b0;
      rotation_direction = 1'b1;
      half_select = 1'b1;
   end
   // One step; levels settle 6 cycles ahead so the synchronisers agree first
   task automatic do_step(input logic dir, input logic half);
      @(negedge clk_sys);
      rotation_direction = dir;
      half_select = half;
      repeat (6) @(negedge clk_sys);
      step_in = 1'b1;
      repeat (4) @(negedge clk_sys);
      step_in = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ===== tb/test_stepper_phase_translator.sv
`timescale 1ns/1ps
`default_nettype none
module test_stepper_phase_translator;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic translator_rstn = 1'b1;
   logic enable = 1'b1;
   logic step_in, rotation_direction, half_select;
   logic inhibit_pair_one, inhibit_pair_two;
   logic [3:0] phase_lines;
   logic [2:0] state_index;
   logic [2:0] idx = 3'h0;
   logic [8:0] exp_q[$];
   logic [8:0] cur, prev, now;
   logic mon_on = 1'b0;
   logic [31:0] rng = 32'h9422124e;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   // Phase table packed, state 1 in the low nibble
   localparam logic [31:0] TBL = 32'h198a2645;
   always #4 clk_sys = ~clk_sys;
   spt_host_model u_host (.clk_sys(clk_sys), .step_in(step_in),
      .rotation_direction(rotation_direction), .half_select(half_select));
   spt_translator u_dut (.clk_sys(clk_sys), .rstn(rstn), .step_in(step_in),
      .rotation_direction(rotation_direction), .half_select(half_select),
      .translator_rstn(translator_rstn), .enable(enable), .phase_lines(phase_lines),
      .inhibit_pair_one(inhibit_pair_one), .inhibit_pair_two(inhibit_pair_two),
      .state_index(state_index));
   ////////////////////////////////////////////////////////////////////////////////
   // Expected outputs; two-phase-on holds both inhibits high
   function automatic logic [8:0] exp_out(input logic [2:0] i, input logic h, input logic en);
      logic [3:0] p;
      logic nrm;
      p = TBL[4*i +: 4];
      nrm = !h && !i[0];
      if (!en) return {i, 6'h00};
      return {i, p, nrm | p[3] | p[2], nrm | p[1] | p[0]};
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [8:0] seen, input logic [8:0] expv);
      checks++;
      if (seen !== expv) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   // Only real changes are queued, since the monitor wakes on output changes
   task automatic note(input logic [8:0] v);
      if (v !== cur) exp_q.push_back(v);
      cur = v;
   endtask
   task automatic step(input logic d, input logic h);
      idx = d ? idx + (h ? 3'h1 : 3'h2) : idx - (h ? 3'h1 : 3'h2);
      note(exp_out(idx, h, enable));
      u_host.do_step(d, h);
   endtask
   task automatic endt(input string s);
      $display("test %s done", s);
   endtask
   task automatic complete_run;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: each output change takes the oldest note; a spare change is an error
   always @(negedge clk_sys) begin
      now = {state_index, phase_lines, inhibit_pair_one, inhibit_pair_two};
      if (mon_on && now !== prev) chk(now, exp_q.size() ? exp_q.pop_front() : ~now);
      prev = now;
   end
   // Hang guard, well above the roughly 1050 cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 8000) begin
         n_fail++;
         complete_run;
      end
   end
   initial begin
      repeat (20) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (10) @(negedge clk_sys);
      cur = exp_out(3'h0, 1'b1, 1'b1);
      chk({state_index, phase_lines, inhibit_pair_one, inhibit_pair_two}, cur);
      mon_on = 1'b1;
      for (int k = 0; k < 9; k++) step(1'b1, 1'b1);
      for (int k = 0; k < 4; k++) step(1'b0, 1'b1);
      endt("half");
      for (int k = 0; k < 6; k++) begin
         rng = xs(rng);
         step(rng[0], 1'b0);
      end
      step(1'b1, 1'b1);
      for (int k = 0; k < 6; k++) begin
         rng = xs(rng);
         step(rng[1], 1'b0);
      end
      endt("full");
      enable = 1'b0;
      note(exp_out(idx, half_select, 1'b0));
      repeat (12) @(negedge clk_sys);
      enable = 1'b1;
      note(exp_out(idx, half_select, 1'b1));
      repeat (12) @(negedge clk_sys);
      translator_rstn = 1'b0;
      idx = 3'h0;
      note(exp_out(idx, half_select, 1'b1));
      repeat (12) @(negedge clk_sys);
      translator_rstn = 1'b1;
      repeat (12) @(negedge clk_sys);
      endt("enable and home");
      // Direction and mode vary freely between steps
      for (int k = 0; k < 24; k++) begin
         rng = xs(rng);
         step(rng[2], rng[3]);
      end
      repeat (20) @(negedge clk_sys);
      chk(9'(exp_q.size()), 9'h000);
      endt("random");
      complete_run;
   end
endmodule
`default_nettype wire
